// [rtl/bpm_ctrl.sv]
/*
 * Backup power mode controller: supply switchover, input and output gating,
 * write protection and host port lockout after recovery, battery-low check.
 * Assumes comparator levels arrive asynchronously and a one-cycle
 * one-second tick from the clock time base on clk_sys.
 */
`timescale 1ns/10ps
`include "bpm_defs.svh"
module bpm_ctrl #(
    parameter int LOCKOUT_CYC  = `BPM_LOCKOUT_CYC,
    parameter int RECOVERY_CYC = `BPM_RECOVERY_CYC,
    parameter int SEC_PER_DAY  = `BPM_SEC_PER_DAY,
    parameter int DAYS_WEEK    = `BPM_DAYS_PER_WEEK
) (
    // Clock and reset
    input  wire logic              clk_sys,
    input  wire logic              rst_n,
    // Supply comparators, asynchronous
    input  wire bpm_pkg::bpm_cmp_s cmp_in,
    // Clock time base and configuration
    input  wire logic              sec_tick,
    input  wire logic              battery_check_enable,
    input  wire logic              irq_src_read,
    // General pins
    input  wire logic [1:0]        gpio_dir_out,
    input  wire logic [1:0]        gpio_out_val,
    input  wire logic [1:0]        gpio_pin_in,
    output logic      [1:0]        gpio_in_val,
    output bpm_pkg::bpm_gpio_s     gpio_pin,
    // Gating and status
    output logic                   backup_mode,
    output logic                   inputs_enable,
    output logic                   func_clk_enable,
    output logic                   rtc_hold,
    output logic                   write_protect,
    output logic                   host_port_enable,
    output logic                   batt_low_pulse,
    output logic                   irq_n
);

    localparam int LW = $clog2(LOCKOUT_CYC > RECOVERY_CYC ? LOCKOUT_CYC + 1 : RECOVERY_CYC + 1);
    localparam int SW = $clog2(SEC_PER_DAY + 1);
    localparam int DW = $clog2(DAYS_WEEK + 1);

    typedef struct packed {
        bpm_pkg::bpm_state_e st;
        logic [LW-1:0]       lock_cnt;
        logic [SW-1:0]       sec_cnt;
        logic [DW-1:0]       day_cnt;
        logic                en_d;
        logic                check_due;
        logic                pulse;
        logic                irq_n;
        logic [1:0]          gin;
        bpm_pkg::bpm_gpio_s  gpio;
        logic                wp;
        logic                hp;
        logic                ie;
    } bpm_state_s;

    bpm_state_s     s_reg;
    bpm_state_s     s_next;
    bpm_pkg::bpm_cmp_s cmp_s;
    logic [1:0]     gpio_s;

    ////////////////////////////////////////////////////////////////////////////
    // Asynchronous inputs pass two flops before use.
    bpm_sync #(.W(5)) u_sync (
        .clk_sys (clk_sys),
        .rst_n   (rst_n),
        .d       ({cmp_in, gpio_pin_in}),
        .q       ({cmp_s, gpio_s})
    );

    ////////////////////////////////////////////////////////////////////////////
    always_comb begin
        s_next       = s_reg;
        s_next.pulse = 1'b0;
        s_next.en_d  = battery_check_enable;
        case (s_reg.st)
            bpm_pkg::BPM_ST_MAIN: begin
                if (cmp_s.main_lt_thresh && cmp_s.main_lt_backup) begin
                    s_next.st = bpm_pkg::BPM_ST_BACKUP;
                end
            end
            bpm_pkg::BPM_ST_BACKUP: begin
                if (!cmp_s.main_lt_backup) begin
                    s_next.st        = bpm_pkg::BPM_ST_LOCK;
                    s_next.lock_cnt  = '0;
                    s_next.check_due = 1'b1;
                end
            end
            bpm_pkg::BPM_ST_LOCK: begin
                if (cmp_s.main_lt_thresh && cmp_s.main_lt_backup) begin
                    s_next.st = bpm_pkg::BPM_ST_BACKUP;
                end else if (s_reg.lock_cnt >= LW'(LOCKOUT_CYC - 1)
                          && s_reg.lock_cnt >= LW'(RECOVERY_CYC - 1)) begin
                    s_next.st = bpm_pkg::BPM_ST_MAIN;
                end else begin
                    s_next.lock_cnt = s_reg.lock_cnt + LW'(1);
                end
            end
            default: begin
                s_next.st = bpm_pkg::BPM_ST_MAIN;
            end
        endcase

        s_next.wp = (s_next.st != bpm_pkg::BPM_ST_MAIN)
                 || (s_next.st == bpm_pkg::BPM_ST_MAIN && s_reg.st == bpm_pkg::BPM_ST_LOCK
                     && s_reg.lock_cnt < LW'(RECOVERY_CYC - 1));
        s_next.hp = (s_next.st == bpm_pkg::BPM_ST_MAIN);
        // inputs live again once out of backup
        s_next.ie = (s_next.st != bpm_pkg::BPM_ST_BACKUP);

        // check when powered and enabled
        // Runs before the day count so a new arming in the same cycle wins.
        if (s_reg.check_due && s_reg.st == bpm_pkg::BPM_ST_MAIN) begin
            s_next.check_due = 1'b0;
            if (battery_check_enable && cmp_s.backup_lt_low) begin
                s_next.pulse = 1'b1;
            end
        end

        if (battery_check_enable && !s_reg.en_d) begin
            s_next.sec_cnt   = '0;
            s_next.day_cnt   = '0;
            s_next.check_due = 1'b1;
        end else if (sec_tick && s_reg.st != bpm_pkg::BPM_ST_BACKUP) begin
            if (s_reg.sec_cnt == SW'(SEC_PER_DAY - 1)) begin
                s_next.sec_cnt = '0;
                if (s_reg.day_cnt == DW'(DAYS_WEEK - 1)) begin
                    s_next.day_cnt = '0;
                    s_next.check_due = 1'b1;
                end else begin
                    s_next.day_cnt = s_reg.day_cnt + DW'(1);
                end
            end else begin
                s_next.sec_cnt = s_reg.sec_cnt + SW'(1);
            end
        end

        // level interrupt held until read; set wins
        if (s_reg.pulse) begin
            s_next.irq_n = 1'b0;
        end else if (irq_src_read) begin
            s_next.irq_n = 1'b1;
        end

        if (s_next.st == bpm_pkg::BPM_ST_BACKUP) begin
            s_next.gpio.out_val  = {2{`BPM_SAFE_LEVEL}};
            s_next.gpio.out_en_n = 2'h0;
        end else begin
            s_next.gpio.out_val  = gpio_out_val;
            s_next.gpio.out_en_n = ~gpio_dir_out;
            s_next.gin = gpio_s & ~gpio_dir_out;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            s_reg.st        <= bpm_pkg::BPM_ST_LOCK;
            s_reg.lock_cnt  <= '0;
            s_reg.sec_cnt   <= '0;
            s_reg.day_cnt   <= '0;
            s_reg.en_d      <= 1'b0;
            s_reg.check_due <= 1'b1;
            s_reg.pulse     <= 1'b0;
            s_reg.irq_n     <= 1'b1;
            s_reg.gin       <= 2'h0;
            s_reg.gpio      <= 4'hf & {2'h0, 2'h3};
            s_reg.wp        <= 1'b1;
            s_reg.hp        <= 1'b0;
            s_reg.ie        <= 1'b1;
        end else begin
            s_reg <= s_next;
        end
    end

    // only the clock runs in backup
    assign backup_mode      = s_reg.st == bpm_pkg::BPM_ST_BACKUP;
    assign inputs_enable    = s_reg.ie;
    assign func_clk_enable  = s_reg.ie;
    assign rtc_hold         = 1'b0;
    assign write_protect    = s_reg.wp;
    assign host_port_enable = s_reg.hp;
    assign batt_low_pulse   = s_reg.pulse;
    assign irq_n            = s_reg.irq_n;
    assign gpio_in_val      = s_reg.gin;
    assign gpio_pin         = s_reg.gpio;

    ////////////////////////////////////////////////////////////////////////////
    // backup entry
    chk_backup_entry: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (s_reg.st == bpm_pkg::BPM_ST_MAIN && cmp_s.main_lt_thresh && cmp_s.main_lt_backup)
        |=> backup_mode) else $error("backup not entered");
    chk_backup_exit: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (backup_mode && !cmp_s.main_lt_backup) |=> s_reg.st == bpm_pkg::BPM_ST_LOCK)
        else $error("backup not left");
    chk_pins_low: assert property (@(posedge clk_sys) disable iff (!rst_n)
        backup_mode |-> gpio_pin.out_val == 2'h0 && gpio_pin.out_en_n == 2'h0)
        else $error("pins not safe in backup");
    chk_inputs_frozen: assert property (@(posedge clk_sys) disable iff (!rst_n)
        backup_mode ##1 backup_mode |-> $stable(gpio_in_val))
        else $error("input changed in backup");
    chk_write_prot: assert property (@(posedge clk_sys) disable iff (!rst_n)
        !write_protect |-> s_reg.st == bpm_pkg::BPM_ST_MAIN)
        else $error("writes open outside main");
    chk_port_lock: assert property (@(posedge clk_sys) disable iff (!rst_n)
        $rose(s_reg.st == bpm_pkg::BPM_ST_LOCK) |-> !host_port_enable [*8])
        else $error("host port open too early");
    chk_pulse_cause: assert property (@(posedge clk_sys) disable iff (!rst_n)
        batt_low_pulse |-> $past(battery_check_enable) && $past(cmp_s.backup_lt_low))
        else $error("pulse without low battery");
    chk_irq_level: assert property (@(posedge clk_sys) disable iff (!rst_n)
        batt_low_pulse |=> !irq_n) else $error("interrupt not raised");

    chk_irq_hold: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (!irq_n && !irq_src_read) |=> !irq_n) else $error("interrupt dropped unread");

    chk_irq_clear: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (!irq_n && irq_src_read && !batt_low_pulse) |=> irq_n) else $error("interrupt not released");

    chk_clk_gate: assert property (@(posedge clk_sys) disable iff (!rst_n)
        backup_mode |-> !func_clk_enable && !rtc_hold) else $error("clock gating wrong in backup");

    chk_inputs_on: assert property (@(posedge clk_sys) disable iff (!rst_n)
        s_reg.st == bpm_pkg::BPM_ST_LOCK |-> inputs_enable) else $error("inputs off after return");

    chk_wp_lock: assert property (@(posedge clk_sys) disable iff (!rst_n)
        s_reg.st != bpm_pkg::BPM_ST_MAIN |-> write_protect) else $error("writes open too early");

    chk_port_main: assert property (@(posedge clk_sys) disable iff (!rst_n)
        host_port_enable |-> s_reg.st == bpm_pkg::BPM_ST_MAIN) else $error("host port open in lock");

    chk_gpio_dir: assert property (@(posedge clk_sys) disable iff (!rst_n)
        $past(rst_n) && !backup_mode |-> gpio_pin.out_en_n == ~$past(gpio_dir_out))
        else $error("pin direction wrong");

    chk_gin_masked: assert property (@(posedge clk_sys) disable iff (!rst_n)
        $past(rst_n) && !backup_mode |-> (gpio_in_val & $past(gpio_dir_out)) == 2'h0)
        else $error("output pin seen as input");

    chk_week_bound: assert property (@(posedge clk_sys) disable iff (!rst_n)
        s_reg.day_cnt < DW'(DAYS_WEEK)) else $error("day count out of range");

endmodule

// [rtl/bpm_defs.svh]
/*
 * Timing counts and the backup pin level for the backup power mode controller.
 * Assumes a 250 MHz system clock and a one-pulse-per-second time base.
 */
`ifndef BPM_DEFS_SVH
`define BPM_DEFS_SVH

// System clock period in nanoseconds.
// Counts are reckoned in nanoseconds so the products stay inside 32 bits.
`define BPM_CLK_PERIOD_NS   4
// Serial port lockout after return to main supply, in microseconds.
`define BPM_LOCKOUT_US      5000
`define BPM_LOCKOUT_CYC     ((`BPM_LOCKOUT_US * 1000) / `BPM_CLK_PERIOD_NS)
// Write protection recovery interval, in microseconds.
`define BPM_RECOVERY_US     5000
`define BPM_RECOVERY_CYC    ((`BPM_RECOVERY_US * 1000) / `BPM_CLK_PERIOD_NS)
// Seconds in a day and days in a week.
`define BPM_SEC_PER_DAY     86400
`define BPM_DAYS_PER_WEEK   7
// Value driven on gated pins in backup mode.
`define BPM_SAFE_LEVEL      1'b0
`define BPM_GPIO_COUNT      2

`endif

// [rtl/bpm_pkg.sv]
/*
 * Types for the backup power mode controller.
 * Assumes bpm_defs.svh is on the include path.
 */
package bpm_pkg;

    typedef enum logic [2:0] {
        BPM_ST_MAIN   = 3'b001,
        BPM_ST_BACKUP = 3'b010,
        BPM_ST_LOCK   = 3'b100
    } bpm_state_e;

    typedef struct packed {
        logic main_lt_thresh;
        logic main_lt_backup;
        logic backup_lt_low;
    } bpm_cmp_s;

    typedef struct packed {
        logic [1:0] out_val;
        logic [1:0] out_en_n;
    } bpm_gpio_s;

endpackage

// [rtl/bpm_sync.sv]
/*
 * Two-flop synchroniser for a bus of asynchronous levels.
 * Assumes the inputs change slowly relative to clk_sys.
 */
`timescale 1ns/10ps
module bpm_sync #(
    parameter int W = 1
) (
    // Clock and reset
    input  wire logic         clk_sys,
    input  wire logic         rst_n,
    // Levels
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);

    logic [W-1:0] meta_reg;

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            meta_reg <= '0;
            q        <= '0;
        end else begin
            meta_reg <= d;
            q        <= meta_reg;
        end
    end

endmodule

// [test/bpm_host_model.sv]
/*
 * Host model: answers the interrupt line by reading the source buffer.
 * Assumes the host port opens only after the lockout, and that
 * read_delay sets how slowly the host reacts.
 */
`timescale 1ns/10ps
module bpm_host_model (
    // Clock and reset
    input  wire logic       clk_sys,
    input  wire logic       rst_n,
    // Device side
    input  wire logic       irq_n,
    input  wire logic       host_port_enable,
    // Behaviour control
    input  wire logic [3:0] read_delay,
    // Host action
    output logic            irq_src_read
);
    logic [3:0] wait_cnt;
    logic       fire;

    initial irq_src_read = 1'b0;
    assign fire = (wait_cnt >= read_delay) && !irq_src_read;

    always @(posedge clk_sys) begin
        if (rst_n === 1'b1 && irq_n === 1'b0 && host_port_enable === 1'b1) begin
            irq_src_read <= #1 fire;
            wait_cnt     <= fire ? 4'h0 : wait_cnt + 4'h1;
        end else begin
            irq_src_read <= #1 1'b0;
            wait_cnt     <= 4'h0;
        end
    end
endmodule

// [test/backup_power_mode_control_tb.sv]
/*
 * Self-checking bench for the backup power mode controller.
 * Assumes shortened lockout and day counts set through parameters.
 */
`timescale 1ns/10ps
module backup_power_mode_control_tb;
    localparam int LOCK_CYC = 20;
    localparam int SPD      = 4;
    localparam int WEEK     = 7;
    typedef struct packed {
        logic [1:0] dir;
        logic [1:0] ov;
        logic [1:0] pin;
        logic [1:0] exp_in;
        logic [1:0] exp_en_n;
    } bpm_row_s;

    logic               clk_sys = 1'b0;
    logic               rst_n = 1'b0;
    bpm_pkg::bpm_cmp_s  cmp_in = 3'b001;
    logic               sec_tick = 1'b0;
    logic               battery_check_enable = 1'b1;
    logic               irq_src_read;
    logic [1:0]         gpio_dir_out = 2'h0;
    logic [1:0]         gpio_out_val = 2'h0;
    logic [1:0]         gpio_pin_in = 2'h0;
    logic [1:0]         gpio_in_val;
    bpm_pkg::bpm_gpio_s gpio_pin;
    logic               backup_mode, inputs_enable, func_clk_enable, rtc_hold;
    logic               write_protect, host_port_enable, batt_low_pulse, irq_n;
    logic [3:0]         read_delay = 4'h8;
    int                 mismatches = 0;
    int                 samples_checked = 0;
    int                 pulse_cnt = 0;
    int                 n;
    bpm_row_s           rows [5] = '{10'b00_11_10_10_11, 10'b01_01_11_10_10,
                                     10'b10_10_01_01_01, 10'b11_11_11_00_00,
                                     10'b00_00_01_01_11};

    always #2 clk_sys = ~clk_sys;
    always @(posedge clk_sys) if (batt_low_pulse === 1'b1) pulse_cnt++;

    bpm_ctrl #(.LOCKOUT_CYC(LOCK_CYC), .RECOVERY_CYC(LOCK_CYC), .SEC_PER_DAY(SPD),
               .DAYS_WEEK(WEEK)) DUT (
        .clk_sys(clk_sys), .rst_n(rst_n), .cmp_in(cmp_in), .sec_tick(sec_tick),
        .battery_check_enable(battery_check_enable), .irq_src_read(irq_src_read),
        .gpio_dir_out(gpio_dir_out), .gpio_out_val(gpio_out_val),
        .gpio_pin_in(gpio_pin_in), .gpio_in_val(gpio_in_val), .gpio_pin(gpio_pin),
        .backup_mode(backup_mode), .inputs_enable(inputs_enable),
        .func_clk_enable(func_clk_enable), .rtc_hold(rtc_hold),
        .write_protect(write_protect), .host_port_enable(host_port_enable),
        .batt_low_pulse(batt_low_pulse), .irq_n(irq_n));

    bpm_host_model host (.clk_sys(clk_sys), .rst_n(rst_n), .irq_n(irq_n),
        .host_port_enable(host_port_enable), .read_delay(read_delay),
        .irq_src_read(irq_src_read));

    ////////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        samples_checked++;
        if (got !== exp) begin
            mismatches++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic cyc(input int k);
        repeat (k) @(posedge clk_sys);
        #1;
    endtask

    // Bounded wait, so a port that never opens cannot hang the run.
    task automatic wait_open();
        n = 0;
        while (host_port_enable !== 1'b1 && n < 100) begin
            cyc(1);
            n++;
        end
    endtask

    task automatic ticks(input int k);
        repeat (k) begin
            sec_tick = 1'b1;
            cyc(1);
            sec_tick = 1'b0;
            cyc(3);
        end
    endtask

    task automatic complete_run();
        $display("checks=%0d mismatches=%0d", samples_checked, mismatches);
        if (mismatches == 0 && samples_checked > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////////
    initial begin
        #40000;
        mismatches++;
        complete_run();
    end

    initial begin
        cyc(3);
        rst_n = 1'b1;
        chk({write_protect, host_port_enable, irq_n, batt_low_pulse}, 8'h0a);
        chk(gpio_pin, 8'h03);
        wait_open();
        chk({7'h0, (n >= LOCK_CYC - 2) && (n <= LOCK_CYC + 2)}, 8'h01);
        chk(write_protect, 8'h00);
        cyc(4);
        chk(pulse_cnt[7:0], 8'h01);
        chk(irq_n, 8'h00);
        cyc(12);
        chk(irq_n, 8'h01);
        $display("test power-up done");
        foreach (rows[i]) begin
            {gpio_dir_out, gpio_out_val, gpio_pin_in} = rows[i][9:4];
            cyc(4);
            chk(gpio_in_val, rows[i].exp_in);
            chk(gpio_pin.out_en_n, rows[i].exp_en_n);
            chk(gpio_pin.out_val & rows[i].dir, rows[i].ov & rows[i].dir);
        end
        $display("test gpio table done");
        cmp_in = 3'b101;
        cyc(5);
        chk(backup_mode, 8'h00);
        cmp_in = 3'b011;
        cyc(5);
        chk(backup_mode, 8'h00);
        cmp_in = 3'b111;
        cyc(5);
        chk(backup_mode, 8'h01);
        gpio_dir_out = 2'b11;
        gpio_out_val = 2'b11;
        gpio_pin_in = 2'b10;
        cyc(5);
        chk(gpio_pin, 8'h00);
        chk(gpio_in_val, 8'h01);
        chk({inputs_enable, func_clk_enable, rtc_hold}, 8'h00);
        $display("test backup entry done");
        cmp_in = 3'b001;
        cyc(5);
        chk(backup_mode, 8'h00);
        chk({inputs_enable, write_protect, host_port_enable, func_clk_enable}, 8'h0d);
        wait_open();
        chk({7'h0, n >= LOCK_CYC - 8}, 8'h01);
        cyc(20);
        chk(pulse_cnt[7:0], 8'h02);
        $display("test recovery done");
        read_delay = 4'h0;
        battery_check_enable = 1'b0;
        cyc(2);
        battery_check_enable = 1'b1;
        cyc(6);
        chk(pulse_cnt[7:0], 8'h03);
        ticks(SPD * WEEK - 1);
        chk(pulse_cnt[7:0], 8'h03);
        ticks(1);
        cyc(3);
        chk(pulse_cnt[7:0], 8'h04);
        cmp_in = 3'b000;
        ticks(SPD * WEEK);
        cyc(3);
        chk(pulse_cnt[7:0], 8'h04);
        chk(irq_n, 8'h01);
        $display("test weekly check done");
        rst_n = 1'b0;
        cyc(3);
        rst_n = 1'b1;
        chk({write_protect, host_port_enable, irq_n}, 8'h05);
        $display("test second reset done");
        complete_run();
    end
endmodule
